// >>> src/prs_pkg.sv
package prs_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_W = 16;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int DATA_LSB = 2;
  localparam int EF_BIT = 1;

  typedef struct packed {
    logic rd;
    logic [13:0] addr;
    logic par;
  } prs_cmd_t;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [13:0] ADR_DUMMY = 14'h0000;
  localparam logic [13:0] ADR_ERR = 14'h335a;
  localparam logic [13:0] ADR_CLR = 14'h3380;
  localparam logic [13:0] ADR_CFG = 14'h3f20;
  localparam logic [13:0] ADR_GAIN = 14'h3ff8;
  localparam logic [13:0] ADR_ANGLE = 14'h3fff;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ANG_WEAK = 13;
  localparam int ANG_STRONG = 12;
  localparam int ES_WEAK = 12;
  localparam int ES_STRONG = 11;
  localparam int ES_RANGE = 10;
  localparam int ES_CALC = 9;
  localparam int ES_CONV = 8;
  localparam int ES_BUSY = 4;
  localparam int ES_ADDR = 2;
  localparam int ES_CLK = 1;
  localparam int ES_PAR = 0;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [5:0] GAIN_RST = 6'h20;
  localparam logic [8:0] CFG_RST = 9'h000;
  localparam logic [1:0] RES_12BIT = 2'h0;
  // Silicon version code, value arbitrary
  localparam logic [2:0] CHIP_VER = 3'h5;
  localparam logic [5:0] GAIN_MIN = 6'h04;
  localparam logic [5:0] GAIN_MAX = 6'h3b;

  // Inputs from the sensing core, same clock
  typedef struct packed {
    logic busy;
    logic major_err;
    logic headroom;
    logic calc_ovf;
    logic conv_ovf;
    logic [5:0] gain_level;
    logic [11:0] angle;
  } prs_core_t;

endpackage : prs_pkg

// >>> src/prs_link.sv
module prs_link (
  input wire logic rstn, // Async reset, active low
  input wire logic sck, // Link clock from host
  input wire logic ss_n, // Frame select, active low
  input wire logic mosi, // Serial data in
  input wire logic [15:0] tx_word, // Answer word, stable in frame
  output logic miso_o, // Serial data out
  output logic miso_oe, // Drive enable for data out
  output logic [15:0] rx_word, // Last frame shifted in
  output logic [4:0] rx_count // Falling edges in last frame
);

  logic start_ff;
  logic [15:0] rx_ff;
  logic [4:0] cnt_ff;
  logic miso_ff;

  // ----------------------------------------
  // Frame start marker
  // ----------------------------------------
  // Preset by select high, so no edge after a frame is needed
  always_ff @(negedge sck or posedge ss_n or negedge rstn) begin
    if (!rstn || ss_n) begin
      start_ff <= 1'b1;
    end else begin
      start_ff <= 1'b0;
    end
  end

  // Sample input on falling edge and count edges
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      rx_ff <= 16'h0000;
      cnt_ff <= 5'h00;
    end else if (start_ff) begin
      rx_ff <= {15'h0000, mosi};
      cnt_ff <= 5'h01;
    end else begin
      rx_ff <= {rx_ff[14:0], mosi};
      cnt_ff <= (cnt_ff == 5'h1f) ? cnt_ff : cnt_ff + 5'h01;
    end
  end

  // Drive on rising edge, MSB first
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      miso_ff <= 1'b0;
    end else if (start_ff) begin
      miso_ff <= tx_word[15];
    end else if (cnt_ff < prs_pkg::FRAME_BITS) begin
      miso_ff <= tx_word[4'(5'h0f - cnt_ff)];
    end else begin
      miso_ff <= 1'b0;
    end
  end

  assign miso_o = miso_ff;
  assign miso_oe = ~ss_n;
  assign rx_word = rx_ff;
  assign rx_count = cnt_ff;

endmodule : prs_link

// >>> src/prs_regs.sv
// Operation
// - Reading the clear command address clears the link error flag.
// - The clear command answers with all-zero data.
// - Bad parity, bad command or bad clock count sets the error flag.
// - Error flag stays set until the clear command runs.
// - Address zero is a dummy write answered with zero data.
// - Nonzero gain hold value stops the gain loop and holds it.
// - Angle word: weak alarm bit 13, strong bit 12, angle 11:0.
// - Both alarms zero while gain lies between its limits.
// - Only weak alarm when gain is above its maximum.
// - Only strong alarm when gain is below its minimum.
// - Both alarms on major error or measurement in progress.
// - Configuration: resolution 13:12 zero, version 11:9, gain 4:3.
// - Every answer frame carries the link error flag.
// - Status bit 12 set when gain at or above maximum.
// - Status bit 11 set when gain at or below minimum.
// - Status bit 10 reports bias headroom limit reached.
// - Status bit 9 reports angle calculation overflow.
// - Status bit 8 reports converter overload or unsettled offset.
// - Status bits 2, 1, 0: bad address, clock count, parity.
// - Status bit 4 follows measurement in progress.
// - Answer bit 1 set after an error in an earlier command.
// - Frame: read flag 15, address 14:1, even parity bit 0.
module prs_regs (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic sck, // Link clock from host
  input wire logic ss_n, // Frame select, active low
  input wire logic mosi, // Serial data in
  output logic miso_o, // Serial data out
  output logic miso_oe, // Drive enable for data out
  input wire prs_pkg::prs_core_t core, // Sensing core state
  output logic angle_start, // Pulse: start a measurement
  output logic gain_hold_en, // Gain loop stopped
  output logic [5:0] gain_hold_value, // Held gain value
  output logic [1:0] gain_setting, // Configured gain
  output logic comm_error_flag // Link error flag
);

  logic [15:0] rx_word;
  logic [4:0] rx_count;
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff;
  logic frame_end;
  prs_pkg::prs_cmd_t cmd;
  logic par_err;
  logic cnt_err;
  logic adr_err;
  logic frame_err;
  logic data_ph_ff;
  logic [13:0] wr_addr_ff;
  logic ef_ff;
  logic [2:0] link_st_ff;
  logic [5:0] gain_hold_ff;
  logic [8:0] cfg_ff;
  logic rsp_pend_ff;
  logic rsp_zero_ff;
  logic [13:0] rsp_addr_ff;
  logic [15:0] tx_ff;
  logic [5:0] gain_eff;
  logic [13:0] angle_word;
  logic [13:0] status_word;
  logic [13:0] cfg_word;
  logic clr_hit;
  logic start_ff;

  // ----------------------------------------
  // Link side, on the link clock
  // ----------------------------------------
  prs_link u_link (
    .rstn(rstn),
    .sck(sck),
    .ss_n(ss_n),
    .mosi(mosi),
    .tx_word(tx_ff),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .rx_word(rx_word),
    .rx_count(rx_count)
  );

  // ----------------------------------------
  // Frame end detection
  // ----------------------------------------
  // Select passes three flops; the edge is seen on the later pair.
  // Link clock is idle by then, so the frame word is stable.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= ss_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end

  assign frame_end = cs_s2_ff & ~cs_s3_ff;

  // ----------------------------------------
  // Frame checks
  // ----------------------------------------
  function automatic logic addr_known(input logic [13:0] a);
    addr_known = (a == prs_pkg::ADR_DUMMY) || (a == prs_pkg::ADR_ERR) ||
                 (a == prs_pkg::ADR_CLR) || (a == prs_pkg::ADR_CFG) ||
                 (a == prs_pkg::ADR_GAIN) || (a == prs_pkg::ADR_ANGLE);
  endfunction : addr_known

  // Command layout and even parity over the whole frame
  assign cmd = prs_pkg::prs_cmd_t'(rx_word);
  assign par_err = ^rx_word;
  assign cnt_err = (rx_count != prs_pkg::FRAME_BITS);
  // Address only checked on command frames, not on write data
  assign adr_err = !data_ph_ff && !addr_known(cmd.addr);
  assign frame_err = par_err | cnt_err | adr_err;
  assign clr_hit = !data_ph_ff && cmd.rd && (cmd.addr == prs_pkg::ADR_CLR)
                   && !frame_err;

  // ----------------------------------------
  // Write sequencing
  // ----------------------------------------
  // A good write command makes the next frame its data frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_ph_ff <= 1'b0;
      wr_addr_ff <= 14'h0000;
    end else if (frame_end) begin
      data_ph_ff <= !data_ph_ff && !frame_err && !cmd.rd;
      wr_addr_ff <= cmd.addr;
    end
  end

  // ----------------------------------------
  // Error flag and link status bits
  // ----------------------------------------
  // Error wins: a clear is only taken from a clean frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ef_ff <= 1'b0;
    end else if (frame_end && frame_err) begin
      ef_ff <= 1'b1;
    end else if (frame_end && clr_hit) begin
      ef_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link_st_ff <= 3'h0;
    end else if (frame_end && frame_err) begin
      link_st_ff <= link_st_ff | {adr_err, cnt_err, par_err};
    end else if (frame_end && clr_hit) begin
      link_st_ff <= 3'h0;
    end
  end

  assign comm_error_flag = ef_ff;

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Data sits in frame bits 15:2; bit 1 is don't care
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gain_hold_ff <= prs_pkg::GAIN_RST;
      cfg_ff <= prs_pkg::CFG_RST;
    end else if (frame_end && data_ph_ff && !par_err && !cnt_err) begin
      if (wr_addr_ff == prs_pkg::ADR_GAIN) begin
        gain_hold_ff <= rx_word[7:2];
      end
      if (wr_addr_ff == prs_pkg::ADR_CFG) begin
        cfg_ff <= rx_word[10:2];
      end
    end
  end

  // Zero hands gain back to the loop
  assign gain_hold_en = (gain_hold_ff != 6'h00);
  assign gain_hold_value = gain_hold_ff;
  assign gain_setting = cfg_ff[4:3];
  assign gain_eff = gain_hold_en ? gain_hold_ff : core.gain_level;

  // ----------------------------------------
  // Measurement start
  // ----------------------------------------
  // Host keeps off while busy; a request then is still passed on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= frame_end && !frame_err && !data_ph_ff && cmd.rd &&
                  (cmd.addr == prs_pkg::ADR_ANGLE);
    end
  end

  assign angle_start = start_ff;

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  // Alarm pair encoding of the angle word
  always_comb begin
    angle_word = {2'b00, core.angle};
    if (core.major_err || core.busy) begin
      angle_word[prs_pkg::ANG_WEAK] = 1'b1;
      angle_word[prs_pkg::ANG_STRONG] = 1'b1;
    end else if (gain_eff > prs_pkg::GAIN_MAX) begin
      angle_word[prs_pkg::ANG_WEAK] = 1'b1;
    end else if (gain_eff < prs_pkg::GAIN_MIN) begin
      angle_word[prs_pkg::ANG_STRONG] = 1'b1;
    end
  end

  // Reserved bits stay zero
  always_comb begin
    status_word = 14'h0000;
    status_word[prs_pkg::ES_WEAK] = (gain_eff >= prs_pkg::GAIN_MAX);
    status_word[prs_pkg::ES_STRONG] = (gain_eff <= prs_pkg::GAIN_MIN);
    status_word[prs_pkg::ES_RANGE] = core.headroom;
    status_word[prs_pkg::ES_CALC] = core.calc_ovf;
    status_word[prs_pkg::ES_CONV] = core.conv_ovf;
    status_word[prs_pkg::ES_BUSY] = core.busy;
    status_word[prs_pkg::ES_ADDR:prs_pkg::ES_PAR] = link_st_ff;
  end

  assign cfg_word = {prs_pkg::RES_12BIT, prs_pkg::CHIP_VER, cfg_ff};

  function automatic logic [13:0] read_word(input logic [13:0] a,
                                            input logic [13:0] ang,
                                            input logic [13:0] st,
                                            input logic [13:0] cf,
                                            input logic [5:0] gh);
    unique case (a)
      prs_pkg::ADR_ANGLE: read_word = ang;
      prs_pkg::ADR_ERR: read_word = st;
      prs_pkg::ADR_CFG: read_word = cf;
      prs_pkg::ADR_GAIN: read_word = {8'h00, gh};
      default: read_word = 14'h0000;
    endcase
  endfunction : read_word

  // ----------------------------------------
  // Answer word
  // ----------------------------------------
  // Built one cycle after frame end, so a written value is seen
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_pend_ff <= 1'b0;
      rsp_zero_ff <= 1'b1;
      rsp_addr_ff <= 14'h0000;
    end else begin
      rsp_pend_ff <= frame_end;
      if (frame_end) begin
        rsp_zero_ff <= frame_err || clr_hit;
        rsp_addr_ff <= data_ph_ff ? wr_addr_ff : cmd.addr;
      end
    end
  end

  // Error flag rides in every answer, parity kept even
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_ff <= 16'h0000;
    end else if (rsp_pend_ff) begin
      tx_ff[15:2] <= rsp_zero_ff ? 14'h0000 :
                     read_word(rsp_addr_ff, angle_word, status_word,
                               cfg_word, gain_hold_ff);
      tx_ff[prs_pkg::EF_BIT] <= ef_ff;
      tx_ff[0] <= ef_ff ^ ((rsp_zero_ff) ? 1'b0 :
                  ^read_word(rsp_addr_ff, angle_word, status_word,
                             cfg_word, gain_hold_ff));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_ef_set;
    frame_end && frame_err |=> ef_ff ##1 tx_ff[prs_pkg::EF_BIT];
  endproperty
  a_ef_set: assert property (p_ef_set) else $error("error flag not set");

  property p_ef_hold;
    ef_ff && !(frame_end && clr_hit) |=> ef_ff;
  endproperty
  a_ef_hold: assert property (p_ef_hold) else $error("error flag lost");

  property p_ef_clr;
    frame_end && clr_hit |=> !ef_ff;
  endproperty
  a_ef_clr: assert property (p_ef_clr) else $error("clear not taken");

  property p_clr_zero;
    frame_end && clr_hit |=> ##1 (tx_ff[15:1] == 15'h0000);
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear answer nonzero");

  property p_tx_par;
    rsp_pend_ff |=> (^tx_ff == 1'b0);
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("answer parity odd");

  property p_weak;
    !core.busy && !core.major_err && gain_eff > prs_pkg::GAIN_MAX |->
      angle_word[13:12] == 2'b10;
  endproperty
  a_weak: assert property (p_weak) else $error("weak alarm wrong");

  property p_mid;
    !core.busy && !core.major_err && gain_eff <= prs_pkg::GAIN_MAX &&
      gain_eff >= prs_pkg::GAIN_MIN |-> angle_word[13:12] == 2'b00;
  endproperty
  a_mid: assert property (p_mid) else $error("alarm in range");

  property p_both;
    core.busy || core.major_err |-> angle_word[13:12] == 2'b11;
  endproperty
  a_both: assert property (p_both) else $error("alarm pair missing");

  property p_hold;
    frame_end && data_ph_ff && !par_err && !cnt_err &&
      wr_addr_ff == prs_pkg::ADR_GAIN && rx_word[7:2] != 6'h00 |=>
      gain_hold_en && gain_hold_value == $past(rx_word[7:2]);
  endproperty
  a_hold: assert property (p_hold) else $error("gain not held");

  property p_start;
    frame_end && !frame_err && !data_ph_ff && cmd.rd &&
      cmd.addr == prs_pkg::ADR_ANGLE |=> angle_start ##1 !angle_start;
  endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");

endmodule : prs_regs

// >>> dv/prs_host.sv
module prs_host (
  output logic sck, // Link clock, still outside frames
  output logic ss_n, // Frame select, active low
  output logic mosi, // Serial data to device
  input wire logic miso_o, // Device data out
  input wire logic miso_oe, // Device drive enable
  output logic [15:0] rx_word, // Answer of last full frame
  output logic rx_v // Pulse: rx_word valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic miso_last;
  logic miso_pin;

  // Released line shows the inverse of its last value, so stale data never passes
  assign miso_pin = miso_oe ? miso_o : ~miso_last;

  // Idle levels
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    rx_word = 16'h0000;
    rx_v = 1'b0;
    miso_last = 1'b0;
  end

  // One frame of nclk clocks, MSB first; short frames are not reported
  task automatic frame(input logic [15:0] w, input int nclk);
    logic [15:0] r;
    r = 16'h0000;
    #3 ss_n = 1'b0;
    #10;
    for (int i = 0; i < nclk; i++) begin
      sck = 1'b1;
      mosi = w[15 - i];
      #6;
      r = {r[14:0], miso_pin};
      miso_last = miso_pin;
      sck = 1'b0;
      #6;
    end
    #10 ss_n = 1'b1;
    mosi = ~mosi;
    if (nclk == 16) begin
      rx_word = r;
      rx_v = 1'b1;
      #1 rx_v = 1'b0;
    end
    // Gap well above what the device needs to load its answer
    #200;
  endtask : frame
endmodule : prs_host

// >>> dv/prs_regs_tb_top.sv
module prs_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, sck, ss_n, mosi, miso_o, miso_oe;
  logic angle_start, gain_hold_en, comm_error_flag, rx_v;
  logic [5:0] gain_hold_value, hold, eff;
  logic [1:0] gain_setting;
  logic [15:0] rx_word, cur_exp;
  logic [15:0] exp_q[$];
  logic [13:0] cfg;
  logic [5:0] gt [6];
  prs_pkg::prs_core_t core, nc;
  int n_mismatch, checks;
  int n_start = 0;

  prs_regs dut (.clk_sys(clk_sys), .rstn(rstn), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .core(core), .angle_start(angle_start),
    .gain_hold_en(gain_hold_en), .gain_hold_value(gain_hold_value),
    .gain_setting(gain_setting), .comm_error_flag(comm_error_flag));
  prs_host host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe), .rx_word(rx_word), .rx_v(rx_v));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // --------
  // Frame builders and models
  // --------
  function automatic logic [15:0] ans(input logic [13:0] d, input logic ef);
    return {d, ef, ^{d, ef}};
  endfunction : ans
  function automatic logic [15:0] cmd(input logic rd, input logic [13:0] a);
    return {rd, a, ^{rd, a}};
  endfunction : cmd
  // Write data frame, bit 1 left at zero
  function automatic logic [15:0] dat(input logic [13:0] d);
    return {d, 1'b0, ^d};
  endfunction : dat
  function automatic logic [13:0] stat(input logic [5:0] g, input logic [2:0] lk);
    logic [13:0] s;
    s = 14'h0000;
    s[prs_pkg::ES_WEAK] = (g >= prs_pkg::GAIN_MAX);
    s[prs_pkg::ES_STRONG] = (g <= prs_pkg::GAIN_MIN);
    s[prs_pkg::ES_RANGE] = core.headroom;
    s[prs_pkg::ES_CALC] = core.calc_ovf;
    s[prs_pkg::ES_CONV] = core.conv_ovf;
    s[prs_pkg::ES_BUSY] = core.busy;
    s[2:0] = lk;
    return s;
  endfunction : stat
  function automatic logic [13:0] ang(input logic [5:0] g);
    logic [13:0] a;
    a = {2'h0, core.angle};
    if (core.major_err || core.busy) a[13:12] = 2'h3;
    else a[13:12] = {g > prs_pkg::GAIN_MAX, g < prs_pkg::GAIN_MIN};
    return a;
  endfunction : ang

  // --------
  // Checking and driving
  // --------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Answer of each frame was predicted when the frame before it was sent
  task automatic xf(input logic [15:0] w, input logic [15:0] nxt, input int nclk = 16);
    if (nclk == 16) exp_q.push_back(cur_exp);
    host.frame(w, nclk);
    cur_exp = nxt;
  endtask : xf

  // Core change lands one edge before predictions read it
  task automatic set_core(input prs_pkg::prs_core_t v);
    @(posedge clk_sys);
    core <= v;
    @(posedge clk_sys);
  endtask : set_core

  // Oldest note against each answer frame
  always @(posedge rx_v) begin
    if (exp_q.size() > 0) chk(rx_word, exp_q.pop_front(), "answer");
    else chk(rx_word, 16'hxxxx, "unexpected answer");
  end

  // Measurement start pulses, one per accepted angle read
  always @(posedge clk_sys) begin
    if (angle_start === 1'b1) n_start++;
  end

  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // Whole run needs about 17 us
  initial begin
    #200us;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    core = '0;
    n_mismatch = 0;
    checks = 0;
    cur_exp = 16'h0000;
    hold = prs_pkg::GAIN_RST;
    gt = '{6'h3c, 6'h3b, 6'h20, 6'h04, 6'h03, 6'h00};
    void'($urandom(92));
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({gain_hold_en, gain_hold_value, gain_setting, comm_error_flag, 6'h00},
      {1'b1, prs_pkg::GAIN_RST, 2'h0, 1'b0, 6'h00}, "reset");
    xf(cmd(1'b0, prs_pkg::ADR_DUMMY), ans(14'h0000, 1'b0));
    xf(dat(14'h0000), ans(14'h0000, 1'b0));
    // Read, modify gain only, write back
    cfg = {prs_pkg::RES_12BIT, prs_pkg::CHIP_VER, prs_pkg::CFG_RST};
    xf(cmd(1'b1, prs_pkg::ADR_CFG), ans(cfg, 1'b0));
    xf(cmd(1'b0, prs_pkg::ADR_CFG), ans(cfg, 1'b0));
    cfg[4:3] = 2'($urandom);
    xf(dat(cfg), ans(cfg, 1'b0));
    chk({14'h0000, gain_setting}, {14'h0000, cfg[4:3]}, "gain setting");
    // Gain hold at and around both limits, then released to the loop
    foreach (gt[i]) begin
      set_core(prs_pkg::prs_core_t'(23'($urandom) & 23'h1fffff));
      xf(cmd(1'b0, prs_pkg::ADR_GAIN), ans({8'h00, hold}, 1'b0));
      xf(dat({8'h00, gt[i]}), ans({8'h00, gt[i]}, 1'b0));
      hold = gt[i];
      chk({9'h000, gain_hold_en, gain_hold_value}, {9'h000, hold != 0, hold}, "hold");
      eff = (hold != 6'h00) ? hold : core.gain_level;
      xf(cmd(1'b1, prs_pkg::ADR_ANGLE), ans(ang(eff), 1'b0));
      xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h0), 1'b0));
    end
    // Busy shows in status; angle is read only after busy drops
    nc = core;
    nc.busy = 1'b1;
    set_core(nc);
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h0), 1'b0));
    nc.busy = 1'b0;
    nc.major_err = 1'b1;
    set_core(nc);
    xf(cmd(1'b1, prs_pkg::ADR_ANGLE), ans(ang(eff), 1'b0));
    nc.major_err = 1'b0;
    set_core(nc);
    // Link faults: parity, clock count, unknown address, then clear
    xf(cmd(1'b1, prs_pkg::ADR_ERR) ^ 16'h0001, ans(14'h0000, 1'b1));
    chk({15'h0000, comm_error_flag}, 16'h0001, "flag set");
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h1), 1'b1));
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h1), 1'b1));
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(14'h0000, 1'b1), 15);
    xf(cmd(1'b1, 14'h1234), ans(14'h0000, 1'b1));
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h7), 1'b1));
    chk({15'h0000, comm_error_flag}, 16'h0001, "flag held");
    xf(cmd(1'b1, prs_pkg::ADR_CLR), ans(14'h0000, 1'b0));
    xf(cmd(1'b1, prs_pkg::ADR_ERR), ans(stat(eff, 3'h0), 1'b0));
    chk({15'h0000, comm_error_flag}, 16'h0000, "flag cleared");
    xf(cmd(1'b1, prs_pkg::ADR_DUMMY), ans(14'h0000, 1'b0));
    repeat (10) @(posedge clk_sys);
    chk({15'h0000, exp_q.size() == 0}, 16'h0001, "all answers seen");
    // Six angle reads in the gain sweep plus one with the major error raised
    chk(16'(n_start), 16'h0007, "start pulses");
    end_sim();
  end
endmodule : prs_regs_tb_top
